// >>> hdl/pcg_defs.svh
// Register offsets, field positions and strap reset values of the clock mode generator
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

// =====================================================================
// Register map
`define PCG_CLOCK_MODE_ADDR   16'h0058

// =====================================================================
// Field positions of clock_mode_config
`define PCG_MUL_HI            15
`define PCG_MUL_LO            12
`define PCG_DIV_BIT           11
`define PCG_CNT_HI            10
`define PCG_CNT_LO            3
`define PCG_ON_BIT            2
`define PCG_NDIV_BIT          1
`define PCG_STAT_BIT          0

// Multiplier field value that selects x1 in PLL mode with the divide bit clear (x8 with it set) and 1/4 in divider mode
`define PCG_MUL_SPECIAL       4'hf

// =====================================================================
// Reset values selected by the straps {a,b,c}
`define PCG_RST_DIV2_OSC_OFF  16'h0000
`define PCG_RST_PLL_X10       16'h9007
`define PCG_RST_PLL_X5        16'h4007
`define PCG_RST_PLL_X2        16'h1007
`define PCG_RST_PLL_X1        16'hf007
`define PCG_RST_DIV2_OSC_ON   16'h0000
`define PCG_RST_DIV4          16'hf000
`define PCG_RST_BYPASS        16'h0000

// =====================================================================
// Timing counts
`define PCG_LOCK_UNIT         16
`define PCG_PERIOD_W          16

`endif

// >>> hdl/pcg_pkg.sv
// Types shared by the clock mode generator modules
package pcg_pkg;

    typedef logic [15:0] pcg_word_t;
    typedef logic [2:0]  pcg_strap_t;

    typedef enum logic [1:0] {
        PCG_PLL_OFF,
        PCG_PLL_ACQUIRE,
        PCG_PLL_LOCKED
    } pcg_pll_state_t;

endpackage

// >>> hdl/pcg_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module pcg_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // No reset: the straps must be caught while reset is still held low
    always_ff @(posedge clock) begin
        stage1   <= async_in;
        sync_out <= stage1;
    end

endmodule

// >>> hdl/pcg_tick_gen.sv
// Fractional tick generator that synthesises the multiplied clock
`timescale 1ns/1ps

module pcg_tick_gen #(
    parameter int PERIOD_W = 16
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                enable,
    input  wire logic [PERIOD_W-1:0] period,
    input  wire logic [4:0]          num,
    input  wire logic [1:0]          den,
    output logic                     tick
);

    localparam int ACC_W = PERIOD_W + 3;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] limit;
    logic [ACC_W-1:0] next_acc;

    // Two ticks per output period, so the step is twice the numerator
    always_comb begin
        limit    = ACC_W'(period) * ACC_W'(den);
        next_acc = acc + ACC_W'({num, 1'b0});
    end

    // Output saturates at one tick per system clock when the ratio is too high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc  <= '0;
            tick <= 1'b0;
        end else if (!enable || limit == '0) begin
            acc  <= '0;
            tick <= 1'b0;
        end else if (next_acc >= limit) begin
            acc  <= next_acc - limit;
            tick <= 1'b1;
        end else begin
            acc  <= next_acc;
            tick <= 1'b0;
        end
    end

endmodule

// >>> hdl/pcg_clock_mode_generator.sv
// Clock mode generator: strap-loaded mode register, PLL model, divider and lock timer
//
// How it works
// (R1) Divider mode divides the reference by 2 or 4
// (R2) PLL mode multiplies the reference by 31 ratios
// (R3) PLL acquires lock first, then keeps tracking
// (R4) Lock timer holds off PLL clocking until lock
// (R5) 16-bit mode register at address 0058h
// (R6) Reset value depends only on three strap pins
// (R7) Straps sampled while reset held low
// (R8) Software may rewrite the mode register later
// (R9) Oscillator enable follows straps at all times
// (R10) Straps 000 load 0000h, oscillator off
// (R11) Straps 001 load 9007h, PLL times 10
// (R12) Straps 010 load 4007h, PLL times 5
// (R13) Straps 100 load 1007h, PLL times 2
// (R14) Straps 110 load f007h, PLL times 1
// (R15) Straps 111 load 0000h, oscillator on
// (R16) Straps 101 load f000h, divide by 4
// (R17) PLL may be powered off in divider mode
// (R18) Software enables PLL and picks multiplier ratio
// (R19) System must not strap reserved pattern 011
// (R20) Run from divider until lock timer expires
`timescale 1ns/1ps
`include "pcg_defs.svh"

module pcg_clock_mode_generator
    import pcg_pkg::*;
#(
    parameter int LOCK_UNIT = `PCG_LOCK_UNIT,
    parameter int PERIOD_W  = `PCG_PERIOD_W
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        mode_strap_a,
    input  wire logic        mode_strap_b,
    input  wire logic        mode_strap_c,
    input  wire logic        ref_clock_input,
    output logic             crystal_return_pin,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rvalid,
    output logic             device_clock,
    output logic             pll_locked,
    output logic             pll_powered,
    output logic             pll_clocking,
    output logic             osc_enable
);

    localparam int LOCK_W = 9 + $clog2(LOCK_UNIT);

    // =====================================================================
    // Decoding helpers

    function automatic pcg_word_t strap_reset_value(input pcg_strap_t s);
        case (s)
            3'b000:  strap_reset_value = `PCG_RST_DIV2_OSC_OFF;   // see (R10)
            3'b001:  strap_reset_value = `PCG_RST_PLL_X10;        // see (R11)
            3'b010:  strap_reset_value = `PCG_RST_PLL_X5;         // see (R12)
            3'b100:  strap_reset_value = `PCG_RST_PLL_X2;         // see (R13)
            3'b110:  strap_reset_value = `PCG_RST_PLL_X1;         // see (R14)
            3'b111:  strap_reset_value = `PCG_RST_DIV2_OSC_ON;    // see (R15)
            3'b101:  strap_reset_value = `PCG_RST_DIV4;           // see (R16)
            default: strap_reset_value = `PCG_RST_BYPASS;
        endcase
    endfunction

    // Multiplier as numerator over denominator: 15 whole ratios plus 16 halves
    function automatic logic [6:0] pll_ratio(input logic [3:0] mul, input logic div);
        logic [4:0] n;
        logic [1:0] d;
        n = 5'(mul) + 5'h01;
        d = 2'h1;
        if (div) begin
            d = 2'h2;
        end else if (mul == `PCG_MUL_SPECIAL) begin
            n = 5'h01;
        end
        pll_ratio = {n, d};
    endfunction

    // =====================================================================
    // Pin synchronisation

    logic [3:0] pins_sync;
    pcg_strap_t strap;
    logic       ref_s;
    logic       ref_q;
    logic       ref_rise;

    pcg_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clock    (clock),
        .async_in ({mode_strap_a, mode_strap_b, mode_strap_c, ref_clock_input}),
        .sync_out (pins_sync)
    );

    assign strap    = pins_sync[3:1];
    assign ref_s    = pins_sync[0];
    assign ref_rise = ref_s & ~ref_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_s;
        end
    end

    // =====================================================================
    // Oscillator control, independent of reset state

    // No reset: the oscillator choice keeps following the straps while reset is held
    always_ff @(posedge clock) begin
        osc_enable         <= (strap != 3'b000);                 // see (R9) see (R10)
        crystal_return_pin <= osc_enable & ~ref_s;
    end

    // =====================================================================
    // Clock mode register

    pcg_word_t cfg;
    logic      loaded;
    logic      write_hit;
    logic      restart;

    assign write_hit = loaded & reg_write & (reg_addr == `PCG_CLOCK_MODE_ADDR);   // see (R5)

    // Straps were held in the synchroniser during reset; caught at the first edge after release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            loaded <= 1'b0;
            cfg    <= '0;
        end else if (!loaded) begin
            loaded <= 1'b1;
            cfg    <= strap_reset_value(strap);                   // see (R6) see (R7) see (R11) see (R12)
        end else if (write_hit) begin
            cfg    <= reg_wdata;                                  // see (R8) see (R18)
        end
    end
    // Reserved pattern 011 falls back to 0000h

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            restart <= 1'b0;
        end else begin
            restart <= !loaded || write_hit;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else if (reg_read && reg_addr == `PCG_CLOCK_MODE_ADDR) begin
            reg_rdata  <= {cfg[15:1], pll_clocking};
            reg_rvalid <= 1'b1;
        end else begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end
    end

    // =====================================================================
    // Decoded mode

    logic       pll_wanted;
    logic       pll_on;
    logic       div4;
    logic [6:0] ratio;

    assign pll_wanted = cfg[`PCG_NDIV_BIT];
    assign pll_on     = cfg[`PCG_NDIV_BIT] | cfg[`PCG_ON_BIT];          // see (R17) see (R18)
    assign div4       = cfg[`PCG_MUL_HI:`PCG_MUL_LO] == `PCG_MUL_SPECIAL;
    assign ratio      = pll_ratio(cfg[`PCG_MUL_HI:`PCG_MUL_LO], cfg[`PCG_DIV_BIT]);   // see (R2)

    // =====================================================================
    // Reference period measurement

    logic [PERIOD_W-1:0] per_cnt;
    logic [PERIOD_W-1:0] period;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            per_cnt <= '0;
            period  <= '0;
        end else if (ref_rise) begin
            per_cnt <= '0;
            period  <= per_cnt + PERIOD_W'(1);
        end else if (per_cnt != '1) begin
            per_cnt <= per_cnt + PERIOD_W'(1);
        end
    end

    // =====================================================================
    // PLL acquisition and tracking

    pcg_pll_state_t pll_state;
    logic           seen_edge;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pll_state <= PCG_PLL_OFF;
            seen_edge <= 1'b0;
        end else if (!pll_on) begin
            pll_state <= PCG_PLL_OFF;
            seen_edge <= 1'b0;
        end else begin
            case (pll_state)
                PCG_PLL_OFF: begin
                    pll_state <= PCG_PLL_ACQUIRE;                 // see (R3)
                    seen_edge <= 1'b0;
                end
                PCG_PLL_ACQUIRE: begin
                    if (ref_rise) begin
                        seen_edge <= 1'b1;
                        if (seen_edge) begin
                            pll_state <= PCG_PLL_LOCKED;          // see (R3)
                        end
                    end
                end
                PCG_PLL_LOCKED: begin
                    pll_state <= PCG_PLL_LOCKED;                  // see (R3)
                end
                default: begin
                    pll_state <= PCG_PLL_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pll_locked  <= 1'b0;
            pll_powered <= 1'b0;
        end else begin
            pll_locked  <= pll_state == PCG_PLL_LOCKED;
            pll_powered <= pll_on;                                // see (R17)
        end
    end

    // =====================================================================
    // Lock timer, counted in reference cycles

    logic [LOCK_W-1:0] lock_cnt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lock_cnt <= '0;
        end else if (restart) begin
            lock_cnt <= LOCK_W'(cfg[`PCG_CNT_HI:`PCG_CNT_LO]) * LOCK_W'(LOCK_UNIT);  // see (R4)
        end else if (ref_rise && pll_on && lock_cnt != '0) begin
            lock_cnt <= lock_cnt - LOCK_W'(1);                    // see (R4)
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pll_clocking <= 1'b0;
        end else begin
            // Restart cycle blocks the switch until the timer has been reloaded
            pll_clocking <= pll_wanted && pll_state == PCG_PLL_LOCKED && lock_cnt == '0 && !restart;   // see (R20)
        end
    end

    // =====================================================================
    // Device clock synthesis

    logic pll_tick;
    logic div_phase;

    pcg_tick_gen #(
        .PERIOD_W (PERIOD_W)
    ) u_tick_gen (
        .clock  (clock),
        .nrst   (nrst),
        .enable (pll_state == PCG_PLL_LOCKED),
        .period (period),
        .num    (ratio[6:2]),
        .den    (ratio[1:0]),
        .tick   (pll_tick)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_phase <= 1'b0;
        end else if (ref_rise) begin
            div_phase <= div4 ? ~div_phase : 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            device_clock <= 1'b0;
        end else if (pll_clocking) begin
            if (pll_tick) begin
                device_clock <= ~device_clock;                    // see (R2)
            end
        end else if (ref_rise && (!div4 || pll_wanted || div_phase)) begin
            device_clock <= ~device_clock;                        // see (R1) see (R20)
        end
    end

endmodule

// >>> verification/pcg_ref_source.sv
// Reference clock source standing in for the crystal or external oscillator
`timescale 1ns/1ps

module pcg_ref_source (
    input  wire logic run,
    input  var  int   half_ns,
    output logic      ref_clk
);
    // Odd start offset keeps reference edges 13 ns after a system clock falling edge until run first drops; restarted edges begin when run rises
    initial begin
        ref_clk = 1'b0;
        #13;
        forever begin
            if (run) begin
                ref_clk = ~ref_clk;
                #(half_ns);
            end else begin
                ref_clk = 1'b0;
                wait (run);
            end
        end
    end
endmodule

// >>> verification/pcg_clock_mode_generator_props.sv
// Checker for the clock mode generator ports
`timescale 1ns/1ps

module pcg_clock_mode_generator_props #(
    parameter int LOCK_UNIT = 16,
    parameter int PERIOD_W  = 16
) (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        mode_strap_a,
    input wire logic        mode_strap_b,
    input wire logic        mode_strap_c,
    input wire logic        ref_clock_input,
    input wire logic        crystal_return_pin,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        device_clock,
    input wire logic        pll_locked,
    input wire logic        pll_powered,
    input wire logic        pll_clocking,
    input wire logic        osc_enable
);
    wire logic [2:0] straps = {mode_strap_a, mode_strap_b, mode_strap_c};

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // =========================================================
    // Register access
    a_read_answered: assert property (reg_read && reg_addr == 16'h0058 |=> reg_rvalid)
        else $error("mapped read not answered");
    a_unmapped_quiet: assert property (reg_read && reg_addr != 16'h0058 |=> !reg_rvalid && reg_rdata == 16'h0000)
        else $error("unmapped read answered");
    a_valid_has_cause: assert property (reg_rvalid |-> $past(reg_read) && $past(reg_addr) == 16'h0058)
        else $error("read valid without mapped read");
    a_write_readback: assert property (reg_write && reg_addr == 16'h0058 ##1 reg_read && reg_addr == 16'h0058 && !reg_write
        |=> (reg_rdata >> 1) == ($past(reg_wdata, 2) >> 1))
        else $error("written value not read back");

    // =========================================================
    // Oscillator and PLL
    a_osc_on_strap: assert property ((straps != 3'h0) [*4] |-> osc_enable)
        else $error("oscillator not following straps");
    a_osc_off_strap: assert property ((straps == 3'h0) [*4] |-> !osc_enable)
        else $error("oscillator on with straps 000");
    a_switch_after_lock: assert property ($rose(pll_clocking) |-> pll_locked && pll_powered)
        else $error("PLL clocking before lock");
    a_acquire_first: assert property ($rose(pll_powered) |-> !pll_locked)
        else $error("lock without acquisition");
    a_off_drops_lock: assert property ($fell(pll_powered) |-> ##[0:2] !pll_locked)
        else $error("lock kept with PLL off");

    cover property (pll_clocking && pll_locked);
    cover property ($fell(pll_clocking) && pll_powered);
    cover property (reg_rvalid && !osc_enable);
endmodule

// >>> verification/pcg_clock_mode_generator_tb_top.sv
// Self-checking bench for the clock mode generator
`timescale 1ns/1ps

module pcg_clock_mode_generator_tb_top;
    logic        clock, nrst, ref_run, ref_clock_input, reg_write, reg_read;
    logic [2:0]  straps;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic        reg_rvalid, device_clock, pll_locked, pll_powered, pll_clocking, osc_enable, xret, v;
    int          ref_half, fails, compares, cycles, t;

    pcg_ref_source REF (.run(ref_run), .half_ns(ref_half), .ref_clk(ref_clock_input));

    pcg_clock_mode_generator #(.LOCK_UNIT(1)) DUT (
        .clock(clock), .nrst(nrst), .mode_strap_a(straps[2]), .mode_strap_b(straps[1]),
        .mode_strap_c(straps[0]), .ref_clock_input(ref_clock_input), .crystal_return_pin(xret),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .device_clock(device_clock),
        .pll_locked(pll_locked), .pll_powered(pll_powered), .pll_clocking(pll_clocking),
        .osc_enable(osc_enable));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // =========================================================
    // Shared tasks
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_near(input string what, input int exp, input int got);
        compares++;
        if (got < exp - 2 || got > exp + 2) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Straps stay off 011, which has no defined mode
    task automatic do_reset(input logic [2:0] p);
        nrst = 1'b0;
        straps = p;
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] w);
        reg_addr = a;
        reg_wdata = w;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
        // Let an edge pass so a following read does not re-raise the strobe at once
        @(negedge clock);
    endtask

    task automatic count_tog(input int n, output int c);
        logic p;
        c = 0;
        p = device_clock;
        repeat (n) begin
            @(negedge clock);
            if (device_clock !== p) c++;
            p = device_clock;
        end
    endtask

    task automatic wait_clocking(output int w);
        w = 0;
        while (pll_clocking !== 1'b1 && w < 2000) begin
            @(negedge clock);
            w++;
        end
    endtask

    // =========================================================
    // Scenarios
    task automatic test_straps;
        logic [2:0]  pat [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
        logic [15:0] val [7] = '{16'h0000, 16'h9007, 16'h4007, 16'h1007, 16'hf007, 16'h0000, 16'hf000};
        for (int i = 0; i < 7; i++) begin
            do_reset(pat[i]);
            reg_rd(16'h0058, rd, v);
            check_val("reset value", val[i] & 16'hfffe, rd & 16'hfffe);
            check_val("osc enable", {15'h0, pat[i] != 3'h0}, {15'h0, osc_enable});
            check_val("pll powered", {15'h0, val[i][2] | val[i][1]}, {15'h0, pll_powered});
        end
        $display("test_straps done");
    endtask

    task automatic test_regs;
        do_reset(3'h1);
        reg_wr(16'h0058, 16'h5a5e);
        reg_rd(16'h0058, rd, v);
        check_val("readback", 16'h5a5e, rd & 16'hfffe);
        reg_wr(16'h0059, 16'hffff);
        reg_rd(16'h0059, rd, v);
        check_val("unmapped valid", 16'h0, {15'h0, v});
        check_val("unmapped data", 16'h0, rd);
        reg_rd(16'h0058, rd, v);
        check_val("mapped valid", 16'h1, {15'h0, v});
        check_val("kept value", 16'h5a5e, rd & 16'hfffe);
        $display("test_regs done");
    endtask

    task automatic test_osc;
        do_reset(3'h1);
        straps = 3'h0;
        repeat (6) @(negedge clock);
        check_val("osc after strap change", 16'h0, {15'h0, osc_enable});
        check_val("return pin idle", 16'h0, {15'h0, xret});
        reg_rd(16'h0058, rd, v);
        check_val("mode kept", 16'h9006, rd & 16'hfffe);
        straps = 3'h1;
        repeat (6) @(negedge clock);
        check_val("osc back on", 16'h1, {15'h0, osc_enable});
        $display("test_osc done");
    endtask

    task automatic test_div;
        do_reset(3'h7);
        repeat (200) @(negedge clock);
        count_tog(800, t);
        check_near("div2 toggles", 8, t);
        check_val("pll off", 16'h0, {14'h0, pll_powered, pll_clocking});
        do_reset(3'h5);
        repeat (200) @(negedge clock);
        count_tog(800, t);
        check_near("div4 toggles", 4, t);
        ref_run = 1'b0;
        repeat (60) @(negedge clock);
        count_tog(400, t);
        check_val("stopped ref toggles", 16'h0, 16'(t));
        ref_run = 1'b1;
        $display("test_div done");
    endtask

    task automatic test_pll;
        logic [15:0] cfg [4] = '{16'h0806, 16'h2806, 16'hf006, 16'he006};
        int          exp [4] = '{4, 12, 8, 120};
        do_reset(3'h1);
        wait_clocking(t);
        check_val("locked clocking", 16'h3, {14'h0, pll_locked, pll_clocking});
        count_tog(400, t);
        check_near("x10 toggles", 80, t);
        reg_wr(16'h0058, 16'h4046);
        repeat (3) @(negedge clock);
        check_val("held by timer", 16'h0, {15'h0, pll_clocking});
        wait_clocking(t);
        check_val("timer length", 16'h1, {15'h0, t >= 700 && t < 2000});
        count_tog(400, t);
        check_near("x5 toggles", 40, t);
        for (int i = 0; i < 4; i++) begin
            reg_wr(16'h0058, cfg[i]);
            repeat (200) @(negedge clock);
            count_tog(400, t);
            check_near("ratio toggles", exp[i], t);
        end
        reg_wr(16'h0058, 16'h0000);
        repeat (10) @(negedge clock);
        check_val("pll disabled", 16'h0, {13'h0, pll_powered, pll_locked, pll_clocking});
        $display("test_pll done");
    endtask

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        {nrst, reg_write, reg_read, reg_addr, reg_wdata, straps} = '0;
        {fails, compares, cycles} = '0;
        ref_run = 1'b1;
        ref_half = 2500;
        @(negedge clock);
        test_straps();
        test_regs();
        test_osc();
        test_div();
        test_pll();
        complete_run();
    end
endmodule

bind pcg_clock_mode_generator pcg_clock_mode_generator_props #(.LOCK_UNIT(LOCK_UNIT), .PERIOD_W(PERIOD_W)) u_props (
    .clock(clock), .nrst(nrst), .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
    .mode_strap_c(mode_strap_c), .ref_clock_input(ref_clock_input), .crystal_return_pin(crystal_return_pin),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .device_clock(device_clock), .pll_locked(pll_locked),
    .pll_powered(pll_powered), .pll_clocking(pll_clocking), .osc_enable(osc_enable));
